// ==== src/fisp_pkg.sv ====
package fisp_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_MICROFRAME_COUNTER  = 8'h2c;
    localparam logic [7:0]  OFS_SCHED_FRAME_BASE    = 8'h34;
    localparam logic [7:0]  OFS_NEXT_QUEUE_HEAD     = 8'h38;
    // field positions
    localparam int          CNT_WIDTH               = 14;
    localparam int          SOF_LSB                 = 3;
    localparam int          SOF_MSB                 = 13;
    localparam int          BASE_LSB                = 12;
    localparam int          QH_LSB                  = 5;
    localparam int          N_1024                  = 12;
    localparam int          N_512                   = 11;
    localparam int          N_256                   = 10;
    // reset values
    localparam logic [31:0] RST_MICROFRAME_COUNTER  = 32'h0000_0000;
    localparam logic [31:0] RST_SCHED_FRAME_BASE    = 32'h0000_0000;
    localparam logic [31:0] RST_NEXT_QUEUE_HEAD     = 32'h0000_0000;
    localparam logic [31:0] RST_SEGMENT_HIGH        = 32'h0000_0000;
    // microframe period
    localparam int          CLK_HZ                  = 40_000_000;
    localparam int          MICROFRAME_NS           = 125_000;
    localparam int          MICROFRAME_CYCLES       = MICROFRAME_NS / (1_000_000_000 / CLK_HZ);
    // list size codes
    typedef enum logic [1:0]
    {
        FISP_LS_1024 = 2'b00,
        FISP_LS_512  = 2'b01,
        FISP_LS_256  = 2'b10,
        FISP_LS_RSVD = 2'b11
    } fisp_list_size_t;
endpackage : fisp_pkg

// ==== src/fisp_uframe_tick.sv ====
module fisp_uframe_tick #(
    parameter int PERIOD = 5000
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // control
    input  wire logic run,
    // output
    output logic      tick
);
    logic [31:0] count_reg;

    // divider producing one pulse per microframe while running
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_reg <= 32'h0000_0000;
            tick      <= 1'b0;
        end
        else if (!run)
        begin
            count_reg <= 32'h0000_0000;
            tick      <= 1'b0;
        end
        else if (count_reg == 32'(PERIOD - 1))
        begin
            count_reg <= 32'h0000_0000;
            tick      <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 32'h0000_0001;
            tick      <= 1'b0;
        end
    end
endmodule : fisp_uframe_tick

// ==== src/fisp_frame_index.sv ====
// Function
// - 14-bit counter advances once per microframe
// - start-of-frame number is counter bits 13:3
// - list index is counter bits N:3
// - each entry used eight consecutive microframes
// - size code 00/01/10 selects N 12/11/10
// - base register keeps address bits 31:12 only
// - fetch address is base plus four times index
// - wide mode takes upper bits from segment
// - queue head pointer holds next head address
// - queue head pointer bits 4:0 read zero
module fisp_frame_index #(
    parameter int PERIOD = fisp_pkg::MICROFRAME_CYCLES
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    // controller state
    input  wire logic        run_stop,
    input  wire logic [1:0]  list_size_select,
    input  wire logic        wide_address_capable,
    input  wire logic [31:0] structure_segment_high,
    // schedule outputs
    output logic [10:0]      sof_frame_number,
    output logic [63:0]      periodic_fetch_addr,
    output logic [63:0]      queue_head_addr,
    output logic             microframe_tick
);
    logic [13:0] microframe_counter_reg;
    logic [19:0] sched_frame_table_base_reg;
    logic [26:0] next_queue_head_ptr_reg;
    logic        tick;
    logic [9:0]  index_next;
    logic [31:0] hi_next;
    logic [13:0] cnt_next;
    logic [31:0] gap_reg;

    // index slice per list size
    function automatic logic [9:0] list_index(input logic [13:0] c, input logic [1:0] sel);
        unique case (sel)
            2'b00:   list_index = c[fisp_pkg::N_1024:fisp_pkg::SOF_LSB];
            2'b01:   list_index = {1'b0, c[fisp_pkg::N_512:fisp_pkg::SOF_LSB]};
            2'b10:   list_index = {2'b00, c[fisp_pkg::N_256:fisp_pkg::SOF_LSB]};
            default: list_index = c[fisp_pkg::N_1024:fisp_pkg::SOF_LSB];
        endcase
    endfunction : list_index

    // address hit decode shared by the write paths
    function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = strobe && (addr == ofs);
    endfunction : reg_hit

    // microframe divider
    fisp_uframe_tick #(
        .PERIOD (PERIOD)
    ) u_tick (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .run      (run_stop),
        .tick     (tick)
    );

    // cycles since the last microframe pulse, for the period check
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            gap_reg <= 32'h0000_0000;
        else if (!run_stop)
            gap_reg <= 32'h0000_0000;
        else if (tick)
            gap_reg <= 32'h0000_0001;
        else
            gap_reg <= gap_reg + 32'h0000_0001;
    end

    assign cnt_next = microframe_counter_reg + 14'h0001;

    // frame counter: advances when running, writable by software
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            microframe_counter_reg <= fisp_pkg::RST_MICROFRAME_COUNTER[13:0];
        else if (reg_hit(reg_wr, reg_addr, fisp_pkg::OFS_MICROFRAME_COUNTER))
            microframe_counter_reg <= reg_wdata[13:0];
        else if (tick && run_stop)
            microframe_counter_reg <= cnt_next;
    end

    // periodic base, low 12 bits dropped
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            sched_frame_table_base_reg <= fisp_pkg::RST_SCHED_FRAME_BASE[31:12];
        else if (reg_hit(reg_wr, reg_addr, fisp_pkg::OFS_SCHED_FRAME_BASE))
            sched_frame_table_base_reg <= reg_wdata[31:12];
    end

    // queue head pointer, 32-byte aligned
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            next_queue_head_ptr_reg <= fisp_pkg::RST_NEXT_QUEUE_HEAD[31:5];
        else if (reg_hit(reg_wr, reg_addr, fisp_pkg::OFS_NEXT_QUEUE_HEAD))
            next_queue_head_ptr_reg <= reg_wdata[31:5];
    end

    // read mux, registered
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                fisp_pkg::OFS_MICROFRAME_COUNTER: reg_rdata <= {18'h0_0000, microframe_counter_reg};
                fisp_pkg::OFS_SCHED_FRAME_BASE:   reg_rdata <= {sched_frame_table_base_reg, 12'h000};
                fisp_pkg::OFS_NEXT_QUEUE_HEAD:    reg_rdata <= {next_queue_head_ptr_reg, 5'h00};
                default:                          reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    assign index_next = list_index(microframe_counter_reg, list_size_select);
    assign hi_next    = wide_address_capable ? structure_segment_high : 32'h0000_0000;

    // schedule address outputs
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sof_frame_number    <= 11'h000;
            periodic_fetch_addr <= 64'h0000_0000_0000_0000;
            queue_head_addr     <= 64'h0000_0000_0000_0000;
            microframe_tick     <= 1'b0;
        end
        else
        begin
            sof_frame_number    <= microframe_counter_reg[13:3];
            periodic_fetch_addr <= {hi_next, sched_frame_table_base_reg, index_next, 2'b00};
            queue_head_addr     <= {hi_next, next_queue_head_ptr_reg, 5'h00};
            microframe_tick     <= tick;
        end
    end

    // checks
    property p_count_step;
        @(posedge core_clk) disable iff (!arst_n)
        (tick && run_stop && !reg_wr) |=> microframe_counter_reg == $past(microframe_counter_reg) + 14'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step");

    property p_hold_stopped;
        @(posedge core_clk) disable iff (!arst_n)
        (!run_stop && !reg_wr) |=> $stable(microframe_counter_reg);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("counter moved while stopped");

    property p_sof;
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> sof_frame_number == $past(microframe_counter_reg[13:3]);
    endproperty
    a_sof: assert property (p_sof) else $error("sof number mismatch");

    property p_index_1024;
        @(posedge core_clk) disable iff (!arst_n)
        (list_size_select == 2'b00 && !wide_address_capable)
            |=> periodic_fetch_addr[11:2] == $past(microframe_counter_reg[12:3]);
    endproperty
    a_index_1024: assert property (p_index_1024) else $error("1024 index wrong");

    property p_index_256;
        @(posedge core_clk) disable iff (!arst_n)
        list_size_select == 2'b10 |=> periodic_fetch_addr[11:10] == 2'b00
            && periodic_fetch_addr[9:2] == $past(microframe_counter_reg[10:3]);
    endproperty
    a_index_256: assert property (p_index_256) else $error("256 index wrong");

    property p_base_low;
        @(posedge core_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == fisp_pkg::OFS_SCHED_FRAME_BASE) |=> reg_rdata[11:0] == 12'h000;
    endproperty
    a_base_low: assert property (p_base_low) else $error("base low bits nonzero");

    property p_qh_low;
        @(posedge core_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == fisp_pkg::OFS_NEXT_QUEUE_HEAD) |=> reg_rdata[4:0] == 5'h00;
    endproperty
    a_qh_low: assert property (p_qh_low) else $error("queue head low bits nonzero");

    property p_qh_write;
        @(posedge core_clk) disable iff (!arst_n)
        (reg_wr && reg_addr == fisp_pkg::OFS_NEXT_QUEUE_HEAD)
            |=> ##1 queue_head_addr[31:5] == $past(reg_wdata[31:5], 2);
    endproperty
    a_qh_write: assert property (p_qh_write) else $error("queue head not stored");

    property p_wide;
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> periodic_fetch_addr[63:32]
            == ($past(wide_address_capable) ? $past(structure_segment_high) : 32'h0000_0000);
    endproperty
    a_wide: assert property (p_wide) else $error("upper address wrong");

    property p_base_fetch;
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> periodic_fetch_addr[31:12] == $past(sched_frame_table_base_reg);
    endproperty
    a_base_fetch: assert property (p_base_fetch) else $error("fetch base wrong");

    // counter load, wrap and divider checks
    property p_count_write;
        @(posedge core_clk) disable iff (!arst_n)
        (reg_wr && reg_addr == fisp_pkg::OFS_MICROFRAME_COUNTER)
            |=> microframe_counter_reg == $past(reg_wdata[13:0]);
    endproperty
    a_count_write: assert property (p_count_write) else $error("counter load lost");

    property p_wrap;
        @(posedge core_clk) disable iff (!arst_n)
        (tick && run_stop && !reg_wr && microframe_counter_reg == 14'h3fff)
            |=> microframe_counter_reg == 14'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_stop_tick;
        @(posedge core_clk) disable iff (!arst_n)
        !run_stop |=> !tick;
    endproperty
    a_stop_tick: assert property (p_stop_tick) else $error("pulse while stopped");

    property p_tick_gap;
        @(posedge core_clk) disable iff (!arst_n)
        (tick && run_stop) |-> gap_reg == 32'(PERIOD);
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("microframe period wrong");

    // list entry and index checks
    property p_entry_reuse;
        @(posedge core_clk) disable iff (!arst_n)
        (tick && run_stop && !reg_wr && microframe_counter_reg[2:0] != 3'h7) ##1 $stable(list_size_select)
            |=> $stable(periodic_fetch_addr[11:2]);
    endproperty
    a_entry_reuse: assert property (p_entry_reuse) else $error("entry left early");

    property p_index_512;
        @(posedge core_clk) disable iff (!arst_n)
        list_size_select == 2'b01 |=> periodic_fetch_addr[11] == 1'b0
            && periodic_fetch_addr[10:2] == $past(microframe_counter_reg[11:3]);
    endproperty
    a_index_512: assert property (p_index_512) else $error("512 index wrong");

    property p_index_rsvd;
        @(posedge core_clk) disable iff (!arst_n)
        list_size_select == 2'b11
            |=> periodic_fetch_addr[11:2] == $past(microframe_counter_reg[12:3]);
    endproperty
    a_index_rsvd: assert property (p_index_rsvd) else $error("reserved size index wrong");

    // register store, read and queue head upper address checks
    property p_base_write;
        @(posedge core_clk) disable iff (!arst_n)
        (reg_wr && reg_addr == fisp_pkg::OFS_SCHED_FRAME_BASE)
            |=> sched_frame_table_base_reg == $past(reg_wdata[31:12]);
    endproperty
    a_base_write: assert property (p_base_write) else $error("base not stored");

    property p_qh_high;
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> queue_head_addr[63:32]
            == ($past(wide_address_capable) ? $past(structure_segment_high) : 32'h0000_0000);
    endproperty
    a_qh_high: assert property (p_qh_high) else $error("queue head upper address wrong");

    property p_cnt_read;
        @(posedge core_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == fisp_pkg::OFS_MICROFRAME_COUNTER)
            |=> reg_rdata == {18'h0_0000, $past(microframe_counter_reg)};
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("counter read wrong");

    property p_base_read;
        @(posedge core_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == fisp_pkg::OFS_SCHED_FRAME_BASE)
            |=> reg_rdata[31:12] == $past(sched_frame_table_base_reg);
    endproperty
    a_base_read: assert property (p_base_read) else $error("base read wrong");

    property p_qh_read;
        @(posedge core_clk) disable iff (!arst_n)
        (reg_rd && reg_addr == fisp_pkg::OFS_NEXT_QUEUE_HEAD)
            |=> reg_rdata[31:5] == $past(next_queue_head_ptr_reg);
    endproperty
    a_qh_read: assert property (p_qh_read) else $error("queue head read wrong");

    c_tick: cover property (@(posedge core_clk) disable iff (!arst_n) tick && run_stop);
    c_wrap: cover property (@(posedge core_clk) disable iff (!arst_n)
        tick && run_stop && microframe_counter_reg == 14'h3fff);
    c_wide: cover property (@(posedge core_clk) disable iff (!arst_n) wide_address_capable);
    c_size_512: cover property (@(posedge core_clk) disable iff (!arst_n) list_size_select == 2'b01);
    c_size_rsvd: cover property (@(posedge core_clk) disable iff (!arst_n) list_size_select == 2'b11);
endmodule : fisp_frame_index

// ==== test/fisp_frame_index_tb_top.sv ====
module fisp_frame_index_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // design inputs and outputs
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic        run_stop = 1'b0;
    logic [1:0]  list_size_select = 2'b00;
    logic        wide_address_capable = 1'b0;
    logic [31:0] structure_segment_high = 32'h0000_0000;
    logic [10:0] sof_frame_number;
    logic [63:0] periodic_fetch_addr;
    logic [63:0] queue_head_addr;
    logic        microframe_tick;
    // bench bookkeeping
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          ticks = 0;
    logic [13:0] c;
    // simulated microframe length and run span
    localparam int SIM_PERIOD = 8;
    localparam int RUN_CYCLES = 84;

    // clock generator
    always #12.5 core_clk = ~core_clk;

    fisp_frame_index #(.PERIOD(SIM_PERIOD)) dut_u (
        .core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .run_stop(run_stop), .list_size_select(list_size_select),
        .wide_address_capable(wide_address_capable), .structure_segment_high(structure_segment_high),
        .sof_frame_number(sof_frame_number), .periodic_fetch_addr(periodic_fetch_addr),
        .queue_head_addr(queue_head_addr), .microframe_tick(microframe_tick));

    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    // read data holds until the next read, so sample one cycle late
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        chk(what, {32'h0000_0000, reg_rdata}, {32'h0000_0000, exp});
    endtask : rd

    // expected fetch address: high half, base, index N:3, entry offset
    function automatic logic [63:0] fexp(input logic [1:0] ls, input logic [13:0] v, input logic [31:0] hi);
        logic [9:0] ix;
        ix = (ls == 2'b01) ? {1'b0, v[11:3]} : (ls == 2'b10) ? {2'b00, v[10:3]} : v[12:3];
        return {hi, 20'hABCD_E, ix, 2'b00};
    endfunction : fexp

    // count tick pulses where they are settled
    always @(negedge core_clk)
        if (microframe_tick === 1'b1)
            ticks++;

    // hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    initial
    begin
        repeat (8) @(negedge core_clk);
        arst_n = 1'b1;
        rd(8'h2c, 32'h0000_0000, "counter reset");
        rd(8'h34, 32'h0000_0000, "base reset");
        rd(8'h38, 32'h0000_0000, "queue head reset");
        wr(8'h30, 32'h1234_5678);
        rd(8'h30, 32'h0000_0000, "unmapped");
        $display("test reset and map done");
        wr(8'h34, 32'hABCD_E000);
        wr(8'h38, 32'h1234_5660);
        rd(8'h34, 32'hABCD_E000, "base readback");
        rd(8'h38, 32'h1234_5660, "queue head readback");
        chk("queue head addr", queue_head_addr, 64'h0000_0000_1234_5660);
        structure_segment_high = 32'h0000_0F0F;
        wide_address_capable = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("wide queue head", queue_head_addr, 64'h0000_0F0F_1234_5660);
        $display("test pointers done");
        wr(8'h2c, 32'h0000_1A5F);
        for (int i = 0; i < 4; i++)
        begin
            list_size_select = 2'(i);
            repeat (3) @(negedge core_clk);
            chk("fetch addr", periodic_fetch_addr, fexp(2'(i), 14'h1A5F, 32'h0000_0F0F));
        end
        chk("sof number", {53'h0, sof_frame_number}, {53'h0, 11'h34B});
        $display("test index done");
        wide_address_capable = 1'b0;
        list_size_select = 2'b00;
        wr(8'h2c, 32'h0000_1A58);
        repeat (3) @(negedge core_clk);
        chk("entry reuse", {54'h0, periodic_fetch_addr[11:2]}, {54'h0, 10'h34B});
        wr(8'h2c, 32'h0000_3FF8);
        ticks = 0;
        run_stop = 1'b1;
        repeat (RUN_CYCLES) @(negedge core_clk);
        run_stop = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("tick count", 64'(ticks), 64'(RUN_CYCLES / SIM_PERIOD));
        c = 14'h3FF8 + 14'(RUN_CYCLES / SIM_PERIOD);
        rd(8'h2c, {18'h0, c}, "counter wrap");
        chk("sof after run", {53'h0, sof_frame_number}, {53'h0, c[13:3]});
        chk("fetch after run", periodic_fetch_addr, fexp(2'b00, c, 32'h0000_0000));
        repeat (20) @(negedge core_clk);
        rd(8'h2c, {18'h0, c}, "counter halted");
        $display("test run done");
        final_report();
    end
endmodule : fisp_frame_index_tb_top
